// ---- peripheral_write_access_guard.sv ----
// peripheral write guard: protection bits, locks, violation flags, interrupt
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module peripheral_write_access_guard (
  // clock and hardware reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire access_guard_pkg::reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // peripheral access being checked
  input wire access_guard_pkg::periph_access_t acc_i,
  output access_guard_pkg::access_verdict_t verdict_o,
  // slave bus reserved-area detection
  input wire access_guard_pkg::slave_error_t slave_err_i,
  // interrupt request
  output logic irq_o
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [31:0] protect [access_guard_pkg::NUM_BRIDGES];
  logic [31:0] flags [access_guard_pkg::NUM_BRIDGES];
  logic [31:0] mask [access_guard_pkg::NUM_BRIDGES];
  logic [3:0] bridge_pending;
  logic [15:0] slave_flags;
  logic [15:0] slave_mask;
  logic irq_enable;
  logic [15:0] last_command;
  logic [31:0] next_rdata;

  // -------------------------------------------------------------------------
  // access check
  // -------------------------------------------------------------------------
  logic hit_protected;
  logic viol_protected;
  logic viol_illegal;
  logic viol_sync;
  logic violation;
  logic [31:0] viol_onehot;

  // the guard is live from reset: no enable bit gates the checks
  assign hit_protected = protect[acc_i.bridge][acc_i.periph];
  assign viol_protected = acc_i.valid && acc_i.write && acc_i.protectable
                          && hit_protected;
  assign viol_illegal = acc_i.valid && acc_i.unimpl;
  assign viol_sync = acc_i.valid && acc_i.write && acc_i.sync_busy;
  assign violation = viol_protected || viol_illegal || viol_sync;
  assign viol_onehot = 32'h0000_0001 << acc_i.periph;

  // a blocked write never reaches the peripheral, so its data is dropped
  assign verdict_o = '{pass: acc_i.valid && !violation,
                       error: violation};

  // -------------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------------
  logic cmd_write;
  logic [1:0] cmd_bridge;
  logic [4:0] cmd_periph;
  logic [7:0] cmd_key;
  logic [31:0] cmd_onehot;
  logic key_clear;
  logic key_set;
  logic key_lock;

  assign cmd_write = reg_req_i.wr
    && reg_req_i.addr == access_guard_pkg::PROTECT_COMMAND_OFS;
  assign cmd_periph =
    reg_req_i.wdata[access_guard_pkg::CMD_PERIPH_LSB +: 5];
  assign cmd_bridge = reg_req_i.wdata[access_guard_pkg::CMD_BRIDGE_LSB +: 2];
  assign cmd_key = reg_req_i.wdata[access_guard_pkg::CMD_KEY_LSB +: 8];
  assign cmd_onehot = 32'h0000_0001 << cmd_periph;
  assign key_clear = cmd_key == access_guard_pkg::KEY_CLEAR;
  assign key_set = cmd_key == access_guard_pkg::KEY_SET;
  assign key_lock = cmd_key == access_guard_pkg::KEY_SET_LOCK;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_command <= 16'h0000;
    end else if (cmd_write) begin
      last_command <= reg_req_i.wdata[access_guard_pkg::CMD_USED_W-1:0];
    end
  end

  // -------------------------------------------------------------------------
  // per-bridge protection, lock, flags and mask
  // -------------------------------------------------------------------------
  // rst_i is the hardware reset; no other reset source reaches this state
  bridge_guard_slice #(.BRIDGE_ID(2'h0)) i_bridge_guard_slice_0 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_req_i(reg_req_i),
    .cmd_write_i(cmd_write),
    .cmd_bridge_i(cmd_bridge),
    .cmd_onehot_i(cmd_onehot),
    .key_clear_i(key_clear),
    .key_set_i(key_set),
    .key_lock_i(key_lock),
    .violation_i(violation),
    .viol_bridge_i(acc_i.bridge),
    .viol_onehot_i(viol_onehot),
    .protect_o(protect[0]),
    .flags_o(flags[0]),
    .mask_o(mask[0]),
    .pending_o(bridge_pending[0])
  );

  bridge_guard_slice #(.BRIDGE_ID(2'h1)) i_bridge_guard_slice_1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_req_i(reg_req_i),
    .cmd_write_i(cmd_write),
    .cmd_bridge_i(cmd_bridge),
    .cmd_onehot_i(cmd_onehot),
    .key_clear_i(key_clear),
    .key_set_i(key_set),
    .key_lock_i(key_lock),
    .violation_i(violation),
    .viol_bridge_i(acc_i.bridge),
    .viol_onehot_i(viol_onehot),
    .protect_o(protect[1]),
    .flags_o(flags[1]),
    .mask_o(mask[1]),
    .pending_o(bridge_pending[1])
  );

  bridge_guard_slice #(.BRIDGE_ID(2'h2)) i_bridge_guard_slice_2 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_req_i(reg_req_i),
    .cmd_write_i(cmd_write),
    .cmd_bridge_i(cmd_bridge),
    .cmd_onehot_i(cmd_onehot),
    .key_clear_i(key_clear),
    .key_set_i(key_set),
    .key_lock_i(key_lock),
    .violation_i(violation),
    .viol_bridge_i(acc_i.bridge),
    .viol_onehot_i(viol_onehot),
    .protect_o(protect[2]),
    .flags_o(flags[2]),
    .mask_o(mask[2]),
    .pending_o(bridge_pending[2])
  );

  bridge_guard_slice #(.BRIDGE_ID(2'h3)) i_bridge_guard_slice_3 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_req_i(reg_req_i),
    .cmd_write_i(cmd_write),
    .cmd_bridge_i(cmd_bridge),
    .cmd_onehot_i(cmd_onehot),
    .key_clear_i(key_clear),
    .key_set_i(key_set),
    .key_lock_i(key_lock),
    .violation_i(violation),
    .viol_bridge_i(acc_i.bridge),
    .viol_onehot_i(viol_onehot),
    .protect_o(protect[3]),
    .flags_o(flags[3]),
    .mask_o(mask[3]),
    .pending_o(bridge_pending[3])
  );

  // -------------------------------------------------------------------------
  // slave bus error flags
  // -------------------------------------------------------------------------
  logic [15:0] slave_set;
  logic [15:0] slave_clr;

  assign slave_set = slave_err_i.valid
                     ? (16'h0001 << slave_err_i.slave) : 16'h0000;
  assign slave_clr = (reg_req_i.wr
                      && reg_req_i.addr == access_guard_pkg::SLAVE_FLAGS_OFS)
                     ? reg_req_i.wdata[15:0] : 16'h0000;

  sticky_flags #(
    .WIDTH(access_guard_pkg::NUM_SLAVES),
    .RESET_VALUE(access_guard_pkg::SLAVE_FLAGS_RESET)
  ) i_sticky_flags (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(slave_set),
    .clear_i(slave_clr),
    .flags_o(slave_flags)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_mask <= access_guard_pkg::SLAVE_MASK_RESET;
    end else if (reg_req_i.wr
                 && reg_req_i.addr == access_guard_pkg::SLAVE_MASK_OFS) begin
      slave_mask <= reg_req_i.wdata[15:0];
    end
  end

  // -------------------------------------------------------------------------
  // interrupt
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_enable <= access_guard_pkg::IRQ_ENABLE_RESET;
    end else if (reg_req_i.wr
                 && reg_req_i.addr == access_guard_pkg::IRQ_ENABLE_OFS) begin
      irq_enable <= reg_req_i.wdata[access_guard_pkg::IRQ_ENABLE_BIT];
    end
  end

  // level output straight from flops, so it follows a flag with no lag
  assign irq_o = irq_enable
                 && (|bridge_pending || |(slave_flags & slave_mask));

  // -------------------------------------------------------------------------
  // register read
  // -------------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0;
    if (reg_req_i.addr == access_guard_pkg::PROTECT_COMMAND_OFS) begin
      next_rdata = {16'h0000, last_command};
    end
    if (reg_req_i.addr == access_guard_pkg::IRQ_ENABLE_OFS) begin
      next_rdata = {31'h0, irq_enable};
    end
    if (reg_req_i.addr == access_guard_pkg::SLAVE_FLAGS_OFS) begin
      next_rdata = {16'h0000, slave_flags};
    end
    if (reg_req_i.addr == access_guard_pkg::SLAVE_MASK_OFS) begin
      next_rdata = {16'h0000, slave_mask};
    end
    for (int i = 0; i < access_guard_pkg::NUM_BRIDGES; i++) begin
      if (reg_req_i.addr == access_guard_pkg::BRIDGE_FLAGS_BASE
          + access_guard_pkg::BRIDGE_STRIDE * 8'(i)) begin
        next_rdata = flags[i];
      end
      if (reg_req_i.addr == access_guard_pkg::BRIDGE_STATUS_BASE
          + access_guard_pkg::BRIDGE_STRIDE * 8'(i)) begin
        next_rdata = protect[i];
      end
      if (reg_req_i.addr == access_guard_pkg::BRIDGE_MASK_BASE
          + access_guard_pkg::BRIDGE_STRIDE * 8'(i)) begin
        next_rdata = mask[i];
      end
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

endmodule

// ---------------------------------------------------------------------------
// sticky event flags, cleared by writing ones
// ---------------------------------------------------------------------------
module sticky_flags #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and hardware reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // events and write-one-to-clear bits
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clear_i,
  // flag state
  output logic [WIDTH-1:0] flags_o
);

  // an event in the cycle of its own clear keeps the flag, so none is lost
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= RESET_VALUE;
    end else begin
      flags_o <= (flags_o & ~clear_i) | set_i;
    end
  end

endmodule

// ---------------------------------------------------------------------------
// one bridge: protection, lock, violation flags and interrupt mask
// ---------------------------------------------------------------------------
module bridge_guard_slice #(
  parameter logic [1:0] BRIDGE_ID = 2'h0
) (
  // clock and hardware reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port and decoded command
  input wire access_guard_pkg::reg_req_t reg_req_i,
  input wire logic cmd_write_i,
  input wire logic [1:0] cmd_bridge_i,
  input wire logic [31:0] cmd_onehot_i,
  input wire logic key_clear_i,
  input wire logic key_set_i,
  input wire logic key_lock_i,
  // violation found by the access check
  input wire logic violation_i,
  input wire logic [1:0] viol_bridge_i,
  input wire logic [31:0] viol_onehot_i,
  // bridge state
  output logic [31:0] protect_o,
  output logic [31:0] flags_o,
  output logic [31:0] mask_o,
  output logic pending_o
);

  localparam logic [7:0] FLAGS_OFS = access_guard_pkg::BRIDGE_FLAGS_BASE
    + access_guard_pkg::BRIDGE_STRIDE * {6'h00, BRIDGE_ID};
  localparam logic [7:0] MASK_OFS = access_guard_pkg::BRIDGE_MASK_BASE
    + access_guard_pkg::BRIDGE_STRIDE * {6'h00, BRIDGE_ID};

  logic cmd_here;
  logic [31:0] cmd_bits;
  logic [31:0] lock;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;

  // -------------------------------------------------------------------------
  // protection and lock
  // -------------------------------------------------------------------------
  // a locked bit stays as it is whatever the key says
  assign cmd_here = cmd_write_i && cmd_bridge_i == BRIDGE_ID;
  assign cmd_bits = cmd_here ? (cmd_onehot_i & ~lock)
                             : 32'h0000_0000;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      protect_o <= access_guard_pkg::PROTECT_RESET;
    end else if (key_clear_i) begin
      protect_o <= protect_o & ~cmd_bits;
    end else if (key_set_i || key_lock_i) begin
      protect_o <= protect_o | cmd_bits;
    end
    // any other key falls through and leaves the bits alone
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock <= access_guard_pkg::LOCK_RESET;
    end else if (key_lock_i) begin
      lock <= lock | cmd_bits;
    end
  end

  // -------------------------------------------------------------------------
  // violation flags and interrupt mask
  // -------------------------------------------------------------------------
  assign set_bits = (violation_i && viol_bridge_i == BRIDGE_ID)
                    ? viol_onehot_i : 32'h0000_0000;
  assign clr_bits = (reg_req_i.wr && reg_req_i.addr == FLAGS_OFS)
                    ? reg_req_i.wdata : 32'h0000_0000;

  sticky_flags #(
    .WIDTH(access_guard_pkg::PERIPH_PER_BRIDGE),
    .RESET_VALUE(access_guard_pkg::FLAGS_RESET)
  ) i_sticky_flags (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(set_bits),
    .clear_i(clr_bits),
    .flags_o(flags_o)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_o <= access_guard_pkg::MASK_RESET;
    end else if (reg_req_i.wr && reg_req_i.addr == MASK_OFS) begin
      mask_o <= reg_req_i.wdata;
    end
  end

  assign pending_o = |(flags_o & mask_o);

endmodule

`default_nettype wire

// ---- access_guard_pkg.sv ----
// constants, field layouts and carrier types of the peripheral write guard
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------

package access_guard_pkg;

  // -------------------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------------------
  localparam int NUM_BRIDGES = 4;
  localparam int PERIPH_PER_BRIDGE = 32;
  localparam int NUM_SLAVES = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // -------------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] PROTECT_COMMAND_OFS = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h04;
  localparam logic [7:0] SLAVE_FLAGS_OFS = 8'h08;
  localparam logic [7:0] SLAVE_MASK_OFS = 8'h0c;
  localparam logic [7:0] BRIDGE_FLAGS_BASE = 8'h10;
  localparam logic [7:0] BRIDGE_STATUS_BASE = 8'h20;
  localparam logic [7:0] BRIDGE_MASK_BASE = 8'h30;
  localparam logic [7:0] BRIDGE_STRIDE = 8'h04;

  // -------------------------------------------------------------------------
  // command word layout and operation keys
  // -------------------------------------------------------------------------
  localparam int CMD_PERIPH_LSB = 0;
  localparam int CMD_BRIDGE_LSB = 5;
  localparam int CMD_KEY_LSB = 8;
  localparam int CMD_USED_W = 16;
  localparam logic [7:0] KEY_CLEAR = 8'h01;
  localparam logic [7:0] KEY_SET = 8'h02;
  localparam logic [7:0] KEY_SET_LOCK = 8'h03;
  localparam int IRQ_ENABLE_BIT = 0;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [31:0] PROTECT_RESET = 32'h0000_0000;
  localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'hffff_ffff;
  localparam logic [15:0] SLAVE_FLAGS_RESET = 16'h0000;
  localparam logic [15:0] SLAVE_MASK_RESET = 16'hffff;
  localparam logic IRQ_ENABLE_RESET = 1'b0;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] bridge;
    logic [4:0] periph;
    logic protectable;
    logic unimpl;
    logic sync_busy;
  } periph_access_t;

  typedef struct packed {
    logic pass;
    logic error;
  } access_verdict_t;

  typedef struct packed {
    logic valid;
    logic [3:0] slave;
  } slave_error_t;

endpackage

// ---- access_guard_sva.sv ----
// checker of the peripheral write guard, bound to its ports
`timescale 1ns/1ps
`default_nettype none

module access_guard_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire access_guard_pkg::reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire access_guard_pkg::periph_access_t acc_i,
  input wire access_guard_pkg::access_verdict_t verdict_o,
  input wire access_guard_pkg::slave_error_t slave_err_i,
  input wire logic irq_o
);
  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_error_no_pass: assert property (
    verdict_o.error |-> !verdict_o.pass) else $error("error with pass");
  chk_unimpl_write: assert property (
    acc_i.valid && acc_i.write && acc_i.unimpl |-> verdict_o.error)
    else $error("unimplemented write not refused");
  chk_unimpl_read: assert property (
    acc_i.valid && !acc_i.write && acc_i.unimpl
    |-> verdict_o.error && !verdict_o.pass)
    else $error("unimplemented read not refused");
  chk_sync_write: assert property (
    acc_i.valid && acc_i.write && acc_i.sync_busy |-> verdict_o.error)
    else $error("write during sync not refused");
  chk_free_write: assert property (
    acc_i.valid && acc_i.write && !acc_i.protectable && !acc_i.unimpl
    && !acc_i.sync_busy |-> verdict_o.pass && !verdict_o.error)
    else $error("unprotectable write refused");
  chk_read_pass: assert property (
    acc_i.valid && !acc_i.write && !acc_i.unimpl |-> verdict_o.pass)
    else $error("plain read refused");
  chk_rdata_idle: assert property (
    !$past(reg_req_i.rd) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  chk_irq_cause: assert property (
    $rose(irq_o)
    |-> $past(verdict_o.error || slave_err_i.valid || reg_req_i.wr))
    else $error("interrupt rose without cause");
endmodule

bind peripheral_write_access_guard access_guard_sva i_access_guard_sva (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o),
  .acc_i(acc_i),
  .verdict_o(verdict_o),
  .slave_err_i(slave_err_i),
  .irq_o(irq_o)
);

`default_nettype wire

// ---- peripheral_master_model.sv ----
// bus master model presenting peripheral accesses to the guard
`timescale 1ns/1ps
`default_nettype none

module peripheral_master_model (
  // clock
  input wire logic sys_clk_i,
  // guard side
  input wire access_guard_pkg::access_verdict_t verdict_i,
  output access_guard_pkg::periph_access_t acc_o
);
  initial acc_o = '0;

  // verdict is combinational, so it is taken mid-cycle once settled
  task access(input access_guard_pkg::periph_access_t a,
              output access_guard_pkg::access_verdict_t v);
    @(posedge sys_clk_i);
    acc_o <= a;
    @(negedge sys_clk_i);
    v = verdict_i;
  endtask

  // released fields show the inverse, never the stale value
  task idle;
    @(posedge sys_clk_i);
    acc_o <= {1'b0, ~acc_o[10:0]};
  endtask
endmodule

`default_nettype wire

// ---- peripheral_write_access_guard_test.sv ----
// self-checking bench of the peripheral write guard
`timescale 1ns/1ps
`default_nettype none

module peripheral_write_access_guard_test;
  localparam logic [7:0] co = access_guard_pkg::PROTECT_COMMAND_OFS;
  localparam logic [7:0] en = access_guard_pkg::IRQ_ENABLE_OFS;
  localparam logic [7:0] sf = access_guard_pkg::SLAVE_FLAGS_OFS;
  localparam logic [7:0] sm = access_guard_pkg::SLAVE_MASK_OFS;
  localparam logic [7:0] fl = access_guard_pkg::BRIDGE_FLAGS_BASE;
  localparam logic [7:0] st = access_guard_pkg::BRIDGE_STATUS_BASE;
  localparam logic [7:0] mk = access_guard_pkg::BRIDGE_MASK_BASE;
  localparam logic [7:0] k_clr = access_guard_pkg::KEY_CLEAR;
  localparam logic [7:0] k_set = access_guard_pkg::KEY_SET;
  localparam logic [7:0] k_lock = access_guard_pkg::KEY_SET_LOCK;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  access_guard_pkg::reg_req_t req = '0;
  access_guard_pkg::slave_error_t serr = '0;
  access_guard_pkg::periph_access_t acc;
  access_guard_pkg::access_verdict_t verdict;
  logic [31:0] rdata;
  logic irq;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  peripheral_write_access_guard i_peripheral_write_access_guard (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .acc_i(acc), .verdict_o(verdict),
    .slave_err_i(serr), .irq_o(irq));
  peripheral_master_model i_peripheral_master_model (
    .sys_clk_i(sys_clk_i), .verdict_i(verdict), .acc_o(acc));

  // -------------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------------
  task finish_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req <= '0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk_i);
    req <= '0;
    @(negedge sys_clk_i);
    chk(rdata, exp);
  endtask

  task cmd(input logic [7:0] k, input logic [1:0] b, input logic [4:0] p);
    wr(co, {16'h0, k, 1'b0, b, p});
  endtask

  task acc_chk(input logic w, input logic [1:0] b, input logic [4:0] p,
               input logic pr, input logic un, input logic sy, input logic e);
    access_guard_pkg::access_verdict_t v;
    i_peripheral_master_model.access('{valid: 1'b1, write: w, bridge: b,
      periph: p, protectable: pr, unimpl: un, sync_busy: sy}, v);
    chk({30'h0, v}, {30'h0, !e, e});
    i_peripheral_master_model.idle();
  endtask

  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task t_reset;
    for (int b = 0; b < 4; b++) rd_chk(st + 8'(4 * b), 32'h0);
    rd_chk(mk, 32'hffff_ffff);
    rd_chk(en, 32'h0);
    rd_chk(8'h80, 32'h0);
    acc_chk(1'b0, 2'd0, 5'd2, 1'b0, 1'b1, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0);
  endtask

  task t_protect;
    cmd(k_set, 2'd1, 5'd5);
    rd_chk(st + 8'h04, 32'h20);
    acc_chk(1'b1, 2'd1, 5'd5, 1'b1, 1'b0, 1'b0, 1'b1);
    acc_chk(1'b1, 2'd1, 5'd5, 1'b0, 1'b0, 1'b0, 1'b0);
    acc_chk(1'b1, 2'd1, 5'd4, 1'b1, 1'b0, 1'b0, 1'b0);
    acc_chk(1'b0, 2'd1, 5'd5, 1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(fl + 8'h04, 32'h20);
    rd_chk(fl + 8'h04, 32'h20);
  endtask

  task t_clear;
    wr(fl + 8'h04, 32'h20);
    rd_chk(fl + 8'h04, 32'h0);
    cmd(k_clr, 2'd1, 5'd5);
    rd_chk(st + 8'h04, 32'h0);
    acc_chk(1'b1, 2'd1, 5'd5, 1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(fl + 8'h04, 32'h0);
  endtask

  task t_lock;
    cmd(k_lock, 2'd2, 5'd0);
    cmd(k_clr, 2'd2, 5'd0);
    rd_chk(st + 8'h08, 32'h1);
    cmd(8'h00, 2'd3, 5'd1);
    cmd(8'h07, 2'd3, 5'd1);
    cmd(8'hff, 2'd3, 5'd1);
    rd_chk(st + 8'h0c, 32'h0);
    rd_chk(co, 32'h0000_ff61);
    cmd(k_set, 2'd3, 5'd1);
    cmd(8'h00, 2'd3, 5'd1);
    rd_chk(st + 8'h0c, 32'h2);
  endtask

  task t_errors;
    acc_chk(1'b0, 2'd0, 5'd2, 1'b0, 1'b1, 1'b0, 1'b1);
    acc_chk(1'b1, 2'd0, 5'd5, 1'b0, 1'b1, 1'b0, 1'b1);
    acc_chk(1'b1, 2'd0, 5'd3, 1'b0, 1'b0, 1'b1, 1'b1);
    acc_chk(1'b0, 2'd0, 5'd4, 1'b0, 1'b0, 1'b1, 1'b0);
    rd_chk(fl, 32'h2c);
  endtask

  task t_irq;
    chk({31'h0, irq}, 32'h0);
    wr(en, 32'h1);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(mk, 32'h0);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(mk, 32'hffff_ffff);
    wr(fl, 32'h2c);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
    @(posedge sys_clk_i);
    serr <= '{valid: 1'b1, slave: 4'h6};
    @(posedge sys_clk_i);
    serr <= '0;
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h1);
    rd_chk(sf, 32'h40);
    wr(sm, 32'h0);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(sm, 32'hffff);
    wr(sf, 32'h40);
    @(negedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
  endtask

  // a second hardware reset must undo the lock and the enable
  task t_rerst;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd_chk(st + 8'h08, 32'h0);
    rd_chk(en, 32'h0);
    cmd(k_set, 2'd2, 5'd0);
    cmd(k_clr, 2'd2, 5'd0);
    rd_chk(st + 8'h08, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_protect();
    t_clear();
    t_lock();
    t_errors();
    t_irq();
    t_rerst();
    finish_test();
  end
endmodule

`default_nettype wire
